// ==== rtl/utmi_parallel_data_interface.sv ====
`timescale 1ns/1ps
// Function
// - Opmode 0 normal, 1 nondriving, 2 bypass
// - TXValid rise starts SYNC
// - TXValid fall starts EOP
// - HS SYNC within 8-16 bit times
// - FS SYNC within one to two clocks
// - Handshake loads holding register next edge
// - RXValid marks full receive holding register
// - RXActive rises on SYNC detect
// - RXActive falls on stuff error, EOP
// - RXError high on receive error
// - ValidH output when receiving, 16-bit
// - Low byte qualified by RXValid only
// - Width high gives 16 bits, 30 MHz
// - Width low gives 8 bits, 60 MHz
// - Unidirectional: receive low, transmit high lanes
// - Width sampled at reset end, static
// - Transceiver select picks HS or FS timing
// - Direction select static, unidirectional when high in 8-bit width
module utmi_parallel_data_interface #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [1:0] opmode,
  input wire logic xcvr_select,
  input wire logic databus16_8,
  input wire logic uni_bidi,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  input wire logic valid_h_in,
  output logic valid_h_out,
  output logic valid_h_oe,
  output logic rx_valid,
  output logic rx_active,
  output logic rx_error,
  output logic clk_sel_30mhz,
  output logic ser_sync_start,
  output logic ser_eop_start,
  output logic [15:0] ser_hold_data,
  output logic ser_hold_hi_valid,
  output logic ser_hold_full,
  input wire logic ser_hold_take,
  output logic ser_bypass,
  output logic ser_drive_en,
  input wire logic des_sync,
  input wire logic [7:0] des_byte,
  input wire logic des_strobe,
  input wire logic des_stuff_err,
  input wire logic des_eop
);

  logic strap_w1, strap_w2, strap_u1, strap_u2;
  logic locked, width16, uni;
  logic tx_en, tx_busy, tx_word;
  logic err_sticky, rsvd_sticky;
  logic [15:0] tx_count, rx_count;
  logic lo_pend;
  logic [7:0] lo_byte;
  logic aw_got, w_got, wr_fire, cnt_clr;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data, rd_word;
  logic [3:0] wr_strb;
  utmi_pkg::reg_sel_t wr_sel, rd_sel;

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  // Register decode shared by read and write
  function automatic utmi_pkg::reg_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
    if ((addr >> 8) != '0) return utmi_pkg::SEL_NONE;
    case (addr[7:0])
      utmi_pkg::ADDR_CTRL: return utmi_pkg::SEL_CTRL;
      utmi_pkg::ADDR_STATUS: return utmi_pkg::SEL_STATUS;
      utmi_pkg::ADDR_TXCNT: return utmi_pkg::SEL_TXCNT;
      utmi_pkg::ADDR_RXCNT: return utmi_pkg::SEL_RXCNT;
      default: return utmi_pkg::SEL_NONE;
    endcase
  endfunction

  // ****************************************
  // Straps and mode pins
  // ****************************************
  // Strap pins are asynchronous: two stages, no reset so valid at release
  always_ff @(posedge aclk) begin
    strap_w1 <= databus16_8;
    strap_w2 <= strap_w1;
    strap_u1 <= uni_bidi;
    strap_u2 <= strap_u1;
  end

  // Width and direction caught once at first edge after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked <= 1'b0;
      width16 <= 1'b0;
      uni <= 1'b0;
    end else if (!locked) begin
      locked <= 1'b1;
      width16 <= strap_w2;
      uni <= strap_u2;
    end
  end

  // Clock rate select and operational mode decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sel_30mhz <= 1'b0;
      ser_bypass <= 1'b0;
      ser_drive_en <= 1'b0;
    end else begin
      clk_sel_30mhz <= width16;
      ser_bypass <= (opmode == utmi_pkg::OPM_BYPASS);
      ser_drive_en <= (opmode == utmi_pkg::OPM_NORMAL) || (opmode == utmi_pkg::OPM_BYPASS);
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  utmi_tx_path #(
    .DATA_W(16)
  ) u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .tx_valid(tx_valid),
    .data_in(data_in),
    .valid_h_in(valid_h_in),
    .width16(width16),
    .uni_bidi(uni),
    .hs_mode(!xcvr_select),
    .tx_allowed(ser_drive_en && tx_en),
    .hold_take(ser_hold_take),
    .tx_ready(tx_ready),
    .hold_data(ser_hold_data),
    .hold_hi_valid(ser_hold_hi_valid),
    .hold_full(ser_hold_full),
    .sync_start(ser_sync_start),
    .eop_start(ser_eop_start),
    .busy(tx_busy),
    .word_pulse(tx_word)
  );

  // ****************************************
  // Receive path
  // ****************************************
  // Packet activity and error flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_active <= 1'b0;
      rx_error <= 1'b0;
    end else begin
      if (des_stuff_err || des_eop) rx_active <= 1'b0;
      else if (des_sync) rx_active <= 1'b1;
      if (des_stuff_err && rx_active) rx_error <= 1'b1;
      else if (des_sync) rx_error <= 1'b0;
    end
  end

  // Byte pairing and receive holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid <= 1'b0;
      valid_h_out <= 1'b0;
      data_out <= 16'h0000;
      lo_pend <= 1'b0;
      lo_byte <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (des_strobe && rx_active) begin
        if (width16 && !lo_pend) begin
          lo_byte <= des_byte;
          lo_pend <= 1'b1;
        end else if (width16) begin
          data_out <= {des_byte, lo_byte};
          valid_h_out <= 1'b1;
          rx_valid <= 1'b1;
          lo_pend <= 1'b0;
        end else begin
          data_out <= {8'h00, des_byte};
          valid_h_out <= 1'b0;
          rx_valid <= 1'b1;
        end
      end else if (lo_pend && (des_eop || des_stuff_err)) begin
        data_out <= {8'h00, lo_byte};
        valid_h_out <= 1'b0;
        rx_valid <= 1'b1;
        lo_pend <= 1'b0;
      end
    end
  end

  // Pin direction: device drives while TXValid is low, low lanes always when unidirectional, lag of one clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_oe <= 16'h0000;
      valid_h_oe <= 1'b0;
    end else begin
      valid_h_oe <= width16 && !tx_valid;
      if (width16) data_oe <= {16{!tx_valid}};
      else if (uni) data_oe <= 16'h00FF;
      else data_oe <= {8'h00, {8{!tx_valid}}};
    end
  end

  // ****************************************
  // AXI4-Lite register slave
  // ****************************************
  assign wr_fire = aw_got && w_got && !bvalid;
  assign wr_sel = reg_decode(wr_addr);
  assign rd_sel = reg_decode(araddr);
  assign cnt_clr = wr_fire && wr_sel == utmi_pkg::SEL_CTRL && wr_strb[0] && wr_data[utmi_pkg::CTRL_CNT_CLR];

  // Address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        awready <= 1'b0;
        wr_addr <= awaddr;
      end else if (wr_fire) begin
        aw_got <= 1'b0;
      end else if (!aw_got && !bvalid && !awready) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (wr_fire) begin
        w_got <= 1'b0;
      end else if (!w_got && !bvalid && !wready) begin
        wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= utmi_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= (wr_sel == utmi_pkg::SEL_NONE) ? utmi_pkg::RESP_SLVERR : utmi_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control register and sticky status, set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_en <= utmi_pkg::CTRL_TX_EN_RESET;
      err_sticky <= 1'b0;
      rsvd_sticky <= 1'b0;
    end else begin
      if (wr_fire && wr_sel == utmi_pkg::SEL_CTRL && wr_strb[0]) tx_en <= wr_data[utmi_pkg::CTRL_TX_EN];
      if (des_stuff_err && rx_active) err_sticky <= 1'b1;
      else if (wr_fire && wr_sel == utmi_pkg::SEL_STATUS && wr_strb[1] && wr_data[utmi_pkg::ST_ERR]) begin
        err_sticky <= 1'b0;
      end
      if (opmode == utmi_pkg::OPM_RSVD) rsvd_sticky <= 1'b1;
      else if (wr_fire && wr_sel == utmi_pkg::SEL_STATUS && wr_strb[1] && wr_data[utmi_pkg::ST_RSVD]) begin
        rsvd_sticky <= 1'b0;
      end
    end
  end

  // Word counters
  always_ff @(posedge aclk) begin
    if (!aresetn || cnt_clr) begin
      tx_count <= 16'h0000;
      rx_count <= 16'h0000;
    end else begin
      if (tx_word) tx_count <= tx_count + 16'h0001;
      if (rx_valid) rx_count <= rx_count + 16'h0001;
    end
  end

  // Read data mux
  always_comb begin
    rd_word = 32'h00000000;
    unique case (rd_sel)
      utmi_pkg::SEL_CTRL: rd_word[utmi_pkg::CTRL_TX_EN] = tx_en;
      utmi_pkg::SEL_STATUS: begin
        rd_word[utmi_pkg::ST_WIDTH16] = width16;
        rd_word[utmi_pkg::ST_UNI] = uni;
        rd_word[utmi_pkg::ST_HS] = !xcvr_select;
        rd_word[utmi_pkg::ST_RXACT] = rx_active;
        rd_word[utmi_pkg::ST_OPMODE +: 2] = opmode;
        rd_word[utmi_pkg::ST_TXBUSY] = tx_busy;
        rd_word[utmi_pkg::ST_ERR] = err_sticky;
        rd_word[utmi_pkg::ST_RSVD] = rsvd_sticky;
      end
      utmi_pkg::SEL_TXCNT: rd_word[15:0] = tx_count;
      utmi_pkg::SEL_RXCNT: rd_word[15:0] = rx_count;
      utmi_pkg::SEL_NONE: rd_word = 32'h00000000;
    endcase
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= utmi_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= (rd_sel == utmi_pkg::SEL_NONE) ? utmi_pkg::RESP_SLVERR : utmi_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid && !arready) begin
      arready <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_opmode_nodrive: assert property ((opmode == utmi_pkg::OPM_NODRIVE) |=> !ser_drive_en && !ser_bypass)
    else $error("Non-driving mode still drives");
  a_rx_active_set: assert property ((des_sync && !des_stuff_err && !des_eop) |=> rx_active)
    else $error("RXActive missed SYNC");
  a_rx_active_clear: assert property ((des_eop || des_stuff_err) |=> !rx_active)
    else $error("RXActive not negated");
  a_rx_error_flag: assert property ((rx_active && des_stuff_err && !des_sync) |=> rx_error [*1] ##1 (rx_error || $past(des_sync)))
    else $error("RXError not raised");
  a_rx_valid_cause: assert property (rx_valid |-> $past(des_strobe || des_eop || des_stuff_err))
    else $error("RXValid without received data");
  a_validh_dir: assert property ((locked && width16 && !tx_valid) |=> valid_h_oe)
    else $error("ValidH not driven on receive");
  a_validh_8bit: assert property ((rx_valid && !width16) |-> !valid_h_out)
    else $error("ValidH set in 8-bit mode");
  a_uni_lanes: assert property ((locked && !width16 && uni) |=> data_oe == 16'h00FF)
    else $error("Unidirectional lanes wrong");
  a_clk_rate: assert property ((locked && $past(locked)) |-> clk_sel_30mhz == width16)
    else $error("Clock select does not follow width");
  a_width_static: assert property ((locked && $past(locked)) |-> $stable(width16) && $stable(uni))
    else $error("Width or direction changed after reset");
  c_rx_pair16: cover property (width16 && rx_valid && valid_h_out);
  c_rx_odd: cover property (width16 && rx_valid && !valid_h_out);
  c_bus_write: cover property (bvalid && bready && bresp == utmi_pkg::RESP_OKAY);

endmodule

// ==== rtl/utmi_pkg.sv ====
package utmi_pkg;

  // ****************************************
  // Operating modes and link timing
  // ****************************************
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [1:0] OPM_NODRIVE = 2'h1;
  localparam logic [1:0] OPM_BYPASS = 2'h2;
  localparam logic [1:0] OPM_RSVD = 2'h3;
  localparam int HS_MBPS = 480;
  localparam int CLK16_MHZ = 30;
  localparam int CLK8_MHZ = 60;
  localparam int HS_SYNC_MIN_BITS = 8;
  localparam int HS_SYNC_MAX_BITS = 16;
  localparam int FS_SYNC_MIN_CLKS = 1;
  localparam int FS_SYNC_MAX_CLKS = 2;
  localparam int BITS_PER_CLK16 = HS_MBPS / CLK16_MHZ;
  localparam int BITS_PER_CLK8 = HS_MBPS / CLK8_MHZ;

  // Whole clocks covering a bit count, never below one
  function automatic int ceil_div1(input int num, input int den);
    int q;
    q = (num + den - 1) / den;
    return (q < 1) ? 1 : q;
  endfunction

  localparam logic [1:0] HS_SYNC_CLKS16 = 2'(ceil_div1(HS_SYNC_MIN_BITS, BITS_PER_CLK16));
  localparam logic [1:0] HS_SYNC_CLKS8 = 2'(ceil_div1(HS_SYNC_MIN_BITS, BITS_PER_CLK8));
  localparam logic [1:0] FS_SYNC_CLKS = 2'(FS_SYNC_MIN_CLKS);

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXCNT = 8'h08;
  localparam logic [7:0] ADDR_RXCNT = 8'h0C;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_CNT_CLR = 1;
  localparam logic CTRL_TX_EN_RESET = 1'b1;
  localparam int ST_WIDTH16 = 0;
  localparam int ST_UNI = 1;
  localparam int ST_HS = 2;
  localparam int ST_RXACT = 3;
  localparam int ST_OPMODE = 4;
  localparam int ST_TXBUSY = 6;
  localparam int ST_ERR = 8;
  localparam int ST_RSVD = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {SEL_CTRL, SEL_STATUS, SEL_TXCNT, SEL_RXCNT, SEL_NONE} reg_sel_t;

endpackage

// ==== rtl/utmi_tx_path.sv ====
`timescale 1ns/1ps
module utmi_tx_path #(
  parameter int DATA_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_valid,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic valid_h_in,
  input wire logic width16,
  input wire logic uni_bidi,
  input wire logic hs_mode,
  input wire logic tx_allowed,
  input wire logic hold_take,
  output logic tx_ready,
  output logic [DATA_W-1:0] hold_data,
  output logic hold_hi_valid,
  output logic hold_full,
  output logic sync_start,
  output logic eop_start,
  output logic busy,
  output logic word_pulse
);

  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA, TX_DRAIN} tx_state_t;

  tx_state_t state;
  logic cap_pend;
  logic [1:0] sync_cnt;
  logic [1:0] sync_dly;
  logic next_tx_ready;

  if (DATA_W != 16) begin : g_chk
    $error("utmi_tx_path supports DATA_W of 16 only");
  end

  // SYNC start latency from speed and width
  always_comb begin
    if (!hs_mode) sync_dly = utmi_pkg::FS_SYNC_CLKS;
    else if (width16) sync_dly = utmi_pkg::HS_SYNC_CLKS16;
    else sync_dly = utmi_pkg::HS_SYNC_CLKS8;
  end

  // Ready only while the holding register can take a word
  always_comb begin
    next_tx_ready = (state == TX_DATA) && tx_valid && !hold_full && !cap_pend && !(tx_ready && tx_valid);
  end

  // Handshake seen now, word loaded one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ready <= 1'b0;
      cap_pend <= 1'b0;
    end else begin
      tx_ready <= next_tx_ready;
      cap_pend <= tx_valid && tx_ready;
    end
  end

  // Holding register toward the serializer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_data <= '0;
      hold_hi_valid <= 1'b0;
      hold_full <= 1'b0;
      word_pulse <= 1'b0;
    end else begin
      word_pulse <= cap_pend;
      if (cap_pend) begin
        hold_full <= 1'b1;
        hold_hi_valid <= width16 && valid_h_in;
        if (width16) hold_data <= data_in;
        else if (uni_bidi) hold_data <= {8'h00, data_in[15:8]};
        else hold_data <= {8'h00, data_in[7:0]};
      end else if (hold_take) begin
        hold_full <= 1'b0;
      end
    end
  end

  // Transmit sequencer: SYNC, data, drain, EOP
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= TX_IDLE;
      sync_cnt <= 2'h0;
      sync_start <= 1'b0;
      eop_start <= 1'b0;
      busy <= 1'b0;
    end else begin
      sync_start <= 1'b0;
      eop_start <= 1'b0;
      busy <= (state != TX_IDLE);
      unique case (state)
        TX_IDLE: begin
          if (tx_valid && tx_allowed) begin
            sync_cnt <= sync_dly - 2'h1;
            state <= TX_SYNC;
          end
        end
        TX_SYNC: begin
          if (sync_cnt == 2'h0) begin
            sync_start <= 1'b1;
            state <= TX_DATA;
          end else begin
            sync_cnt <= sync_cnt - 2'h1;
          end
        end
        TX_DATA: begin
          if (!tx_valid) state <= TX_DRAIN;
        end
        TX_DRAIN: begin
          if (!hold_full && !cap_pend) begin
            eop_start <= 1'b1;
            state <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_sync_hs_latency: assert property ((state == TX_IDLE && tx_valid && tx_allowed && hs_mode) |-> ##[2:3] sync_start)
    else $error("HS SYNC start outside window");
  a_sync_fs_latency: assert property ((state == TX_IDLE && tx_valid && tx_allowed && !hs_mode) |-> ##[2:3] sync_start)
    else $error("FS SYNC start outside window");
  a_hold_load: assert property ((tx_valid && tx_ready && width16) |=> ##1 (hold_full && hold_data == $past(data_in)))
    else $error("Holding register not loaded");
  a_eop_after_drop: assert property ($rose(eop_start) |-> $past(state == TX_DRAIN) && !$past(tx_valid, 2))
    else $error("EOP without TXValid drop");
  c_tx_eop: cover property (sync_start ##[1:40] eop_start);

endmodule

// ==== dv/sie_model.sv ====
`timescale 1ns/1ps
// ************************************
// Link controller model
// ************************************
module sie_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [3:0] n_words,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [15:0] data_out,
  input wire logic valid_h_out,
  output logic tx_valid = 1'h0,
  output logic [15:0] data_in = 16'h0,
  output logic valid_h_in = 1'h0,
  output logic [15:0] rx_word = 16'h0,
  output logic rx_hi = 1'h0
);
  logic [3:0] left = 4'h0;
  logic taken = 1'h0;

  // Packet of words from 16'hA500 upward; the bus keeps toggling while released
  always @(posedge aclk) begin
    taken <= tx_valid && tx_ready;
    if (go && !tx_valid) begin
      tx_valid <= 1'h1;
      left <= n_words;
      data_in <= 16'hA500;
      valid_h_in <= 1'h1;
    end else if (taken) begin
      left <= left - 4'h1;
      data_in <= data_in + 16'h1;
      if (left == 4'h1) begin
        tx_valid <= 1'h0;
        data_in <= ~data_in;
      end
    end else if (!tx_valid) begin
      data_in <= ~data_in;
      valid_h_in <= ~valid_h_in;
    end
  end

  // Received word is taken on the edge that shows it valid
  always @(posedge aclk) begin
    if (rx_valid) begin
      rx_word <= data_out;
      rx_hi <= valid_h_out;
    end
  end
endmodule

// ==== dv/utmi_parallel_data_interface_bench.sv ====
`timescale 1ns/1ps
module utmi_parallel_data_interface_bench;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, des_byte = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, n_words = 4'h3;
  logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, valid_h_in, valid_h_out, valid_h_oe, rx_hi;
  logic [1:0] bresp, rresp, opmode = 2'h0;
  logic xcvr_select = 1'h0, databus16_8 = 1'h1, uni_bidi = 1'h0, go = 1'h0, ser_hold_take = 1'h0;
  logic des_sync = 1'h0, des_strobe = 1'h0, des_stuff_err = 1'h0, des_eop = 1'h0;
  logic [15:0] data_in, data_out, data_oe, ser_hold_data, rx_word;
  logic rx_valid, rx_active, rx_error, clk_sel_30mhz, ser_sync_start, ser_eop_start;
  logic ser_hold_hi_valid, ser_hold_full, ser_bypass, ser_drive_en;
  logic [16:0] got [$];
  int fail_count = 0, compares = 0, syncs = 0, eops = 0;

  // ************************************
  // Clock, design and partner
  // ************************************
  always #10 aclk = ~aclk;

  utmi_parallel_data_interface #(.ADDR_W(8)) i_utmi_parallel_data_interface (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .opmode, .xcvr_select, .databus16_8, .uni_bidi, .tx_valid, .tx_ready, .data_in,
    .data_out, .data_oe, .valid_h_in, .valid_h_out, .valid_h_oe, .rx_valid, .rx_active, .rx_error, .clk_sel_30mhz,
    .ser_sync_start, .ser_eop_start, .ser_hold_data, .ser_hold_hi_valid, .ser_hold_full, .ser_hold_take,
    .ser_bypass, .ser_drive_en, .des_sync, .des_byte, .des_strobe, .des_stuff_err, .des_eop);

  sie_model i_sie_model (.aclk, .go, .n_words, .tx_ready, .rx_valid, .data_out, .valid_h_out, .tx_valid,
    .data_in, .valid_h_in, .rx_word, .rx_hi);

  // Serializer stand-in: consumes each held word and counts start pulses
  always @(posedge aclk) begin
    ser_hold_take <= ser_hold_full && !ser_hold_take;
    if (ser_hold_full && !ser_hold_take) got.push_back({ser_hold_hi_valid, ser_hold_data});
    syncs <= syncs + int'(ser_sync_start);
    eops <= eops + int'(ser_eop_start);
  end

  // ************************************
  // Shared tasks
  // ************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    check(bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    check(rdata, exp);
    check(rresp, er);
  endtask

  task automatic pulse_wait(input int cycles);
    repeat (cycles) @(posedge aclk);
  endtask

  // ************************************
  // Scenarios
  // ************************************
  // Reset values, captured straps (16-bit, high speed: status 5) and an unmapped place
  task automatic t_regs;
    axi_rd(utmi_pkg::ADDR_CTRL, 32'h1, utmi_pkg::RESP_OKAY);
    axi_rd(utmi_pkg::ADDR_STATUS, 32'h5, utmi_pkg::RESP_OKAY);
    axi_rd(8'h10, 32'h0, utmi_pkg::RESP_SLVERR);
    axi_wr(8'h10, 32'hFFFFFFFF, utmi_pkg::RESP_SLVERR);
    check(clk_sel_30mhz, 1'h1);
    check({data_oe, valid_h_oe}, 17'h1FFFF);
  endtask

  // Every mode code, reserved one included, then its sticky flag cleared
  task automatic t_opmode;
    for (int op = 0; op < 4; op++) begin
      opmode <= 2'(op);
      pulse_wait(3);
      check(ser_drive_en, op == 0 || op == 2);
      check(ser_bypass, op == 2);
    end
    opmode <= utmi_pkg::OPM_NORMAL;
    pulse_wait(3);
    axi_rd(utmi_pkg::ADDR_STATUS, 32'h205, utmi_pkg::RESP_OKAY);
    axi_wr(utmi_pkg::ADDR_STATUS, 32'h200, utmi_pkg::RESP_OKAY);
  endtask

  // One three-word packet; SYNC delay counted from the edge that raises transmit valid
  task automatic t_tx(input logic fs);
    int n, s0, e0;
    xcvr_select <= fs;
    got.delete();
    s0 = syncs;
    e0 = eops;
    @(posedge aclk);
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!ser_sync_start && n < 9);
    if (fs) check(n >= 3 && n <= 4, 1'h1);
    else check(n, 3);
    check({data_oe, valid_h_oe}, 17'h0);
    n = 0;
    while (eops == e0 && n < 60) begin
      @(posedge aclk);
      n++;
    end
    check(got.size(), 3);
    for (int i = 0; i < got.size(); i++) check(got[i], 32'h1A500 + i);
    check(syncs - s0, 1);
    check(eops - e0, 1);
  endtask

  // Two bytes form one word, then end of packet
  task automatic t_rx;
    des_sync <= 1'h1;
    @(posedge aclk);
    des_sync <= 1'h0;
    @(posedge aclk);
    check(rx_active, 1'h1);
    des_strobe <= 1'h1;
    des_byte <= 8'h3C;
    @(posedge aclk);
    des_byte <= 8'hC3;
    @(posedge aclk);
    des_strobe <= 1'h0;
    des_eop <= 1'h1;
    @(posedge aclk);
    des_eop <= 1'h0;
    pulse_wait(2);
    check({rx_hi, rx_word}, 17'h1C33C);
    check(rx_active, 1'h0);
  endtask

  // Odd byte cut short by a stuffing fault; error flag shows and is cleared
  task automatic t_err;
    des_sync <= 1'h1;
    @(posedge aclk);
    des_sync <= 1'h0;
    des_strobe <= 1'h1;
    des_byte <= 8'h5A;
    @(posedge aclk);
    des_strobe <= 1'h0;
    des_stuff_err <= 1'h1;
    @(posedge aclk);
    des_stuff_err <= 1'h0;
    pulse_wait(3);
    check({rx_hi, rx_word[7:0]}, 9'h05A);
    check(rx_error, 1'h1);
    check(rx_active, 1'h0);
    // Transceiver select is still on full speed here, so the speed bit reads 0
    axi_rd(utmi_pkg::ADDR_STATUS, 32'h101, utmi_pkg::RESP_OKAY);
    axi_wr(utmi_pkg::ADDR_STATUS, 32'h100, utmi_pkg::RESP_OKAY);
    axi_rd(utmi_pkg::ADDR_STATUS, 32'h1, utmi_pkg::RESP_OKAY);
    // Six words sent, two received, then both counters cleared
    axi_rd(utmi_pkg::ADDR_TXCNT, 32'h6, utmi_pkg::RESP_OKAY);
    axi_rd(utmi_pkg::ADDR_RXCNT, 32'h2, utmi_pkg::RESP_OKAY);
    axi_wr(utmi_pkg::ADDR_CTRL, 32'h3, utmi_pkg::RESP_OKAY);
    axi_rd(utmi_pkg::ADDR_RXCNT, 32'h0, utmi_pkg::RESP_OKAY);
  endtask

  // Mid-run reset into 8-bit unidirectional operation: lanes, one byte received, a three-byte packet sent
  task automatic t_uni;
    aresetn <= 1'h0;
    databus16_8 <= 1'h0;
    uni_bidi <= 1'h1;
    pulse_wait(3);
    aresetn <= 1'h1;
    pulse_wait(3);
    check(clk_sel_30mhz, 1'h0);
    check(data_oe, 16'h00FF);
    axi_rd(utmi_pkg::ADDR_STATUS, 32'h2, utmi_pkg::RESP_OKAY);
    des_sync <= 1'h1;
    @(posedge aclk);
    des_sync <= 1'h0;
    des_strobe <= 1'h1;
    des_byte <= 8'h96;
    @(posedge aclk);
    des_strobe <= 1'h0;
    pulse_wait(2);
    check({rx_hi, rx_word}, 17'h00096);
    got.delete();
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    pulse_wait(30);
    check(got.size(), 3);
    check(got[0], 17'h000A5);
  endtask

  // ************************************
  // Main sequence and watchdog
  // ************************************
  initial begin
    pulse_wait(3);
    aresetn <= 1'h1;
    pulse_wait(3);
    t_regs();
    t_opmode();
    t_tx(1'h0);
    t_tx(1'h1);
    t_rx();
    t_err();
    t_uni();
    tally_and_finish();
  end

  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule
